// File: verilog/curtain_receiver.sv
// Receiver beam evaluation, safety output pair, indicators, display and APB registers.
// Assumes beam, test and reset pins are asynchronous; lockout_fault comes from pclk logic.
//
// The implementer's own choices: the APB slave port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module curtain_receiver #(
    parameter int NUM_BEAMS = 16,
    parameter int NUM_ZONES = 8,
    parameter int unsigned SLOT_CYCLES = curtain_pkg::FLASH_SLOT_CYC,
    parameter int unsigned RESET_MIN_CYCLES = curtain_pkg::RESET_MIN_CYC,
    parameter int unsigned RESET_MAX_CYCLES = curtain_pkg::RESET_MAX_CYC
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Optical and emitter pins
    input wire logic [NUM_BEAMS-1:0] beam_blocked,
    input wire logic test_input_open,
    input wire logic reset_switch_closed,
    input wire logic lockout_fault,
    // Machine side
    output logic [1:0] safety_output_pair,
    output logic irq,
    // Indicators
    output curtain_pkg::rx_lamps_t rx_lamps,
    output curtain_pkg::tx_lamps_t tx_lamps,
    output logic [NUM_ZONES-1:0] zone_green,
    output logic [NUM_ZONES-1:0] zone_red,
    output curtain_pkg::display_t display
);
    import curtain_pkg::*;

    localparam int BPZ = NUM_BEAMS / NUM_ZONES;

    typedef enum {ST_LAMP, ST_SCAN, ST_RUN, ST_LOCKOUT} state_t;

    logic [NUM_BEAMS-1:0] beams;
    logic test_open;
    logic switch_closed;
    state_t state_ff;
    ctrl_t ctrl_ff;
    logic [EV_NUM-1:0] ev_status_ff;
    logic [EV_NUM-1:0] ev_mask_ff;
    logic [31:0] prdata_ff;
    logic pslverr_ff;
    logic [31:0] slot_cnt_ff;
    logic [2:0] slot_ff;
    logic [4:0] phase_timer_ff;
    logic [31:0] hold_cnt_ff;
    logic switch_prev_ff;
    logic latched_ff;
    logic [1:0] outputs_ff;
    rx_lamps_t rx_lamps_ff;
    tx_lamps_t tx_lamps_ff;
    logic [NUM_ZONES-1:0] zone_green_ff;
    logic [NUM_ZONES-1:0] zone_red_ff;
    display_t display_ff;

    pin_sync3 #(.WIDTH(NUM_BEAMS + 2), .INIT('0)) u_pin_sync (
        .pclk(pclk),
        .presetn(presetn),
        .pin_in({beam_blocked, test_input_open, reset_switch_closed}),
        .sync_out({beams, test_open, switch_closed})
    );

    function automatic logic [7:0] count_ones(input logic [NUM_BEAMS-1:0] v);
        logic [7:0] n;
        n = 8'h00;
        for (int i = 0; i < NUM_BEAMS; i++) begin
            n = n + {7'h00, v[i]};
        end
        return n;
    endfunction : count_ones

    // Beam evaluation
    logic [7:0] blocked_count;
    logic triple_run;
    logic permitted;
    logic clear_ok;
    logic run_ok;
    always_comb begin
        triple_run = 1'b0;
        for (int i = 0; i + 2 < NUM_BEAMS; i++) begin
            triple_run = triple_run | (beams[i] & beams[i+1] & beams[i+2]);
        end
    end
    assign blocked_count = count_ones(beams);
    assign permitted = ctrl_ff.reduced_resolution_switch & ~beams[0] & ~triple_run;
    assign clear_ok = (blocked_count == 8'h00) | permitted;
    assign run_ok = (state_ff == ST_RUN) & ~test_open & clear_ok;

    // Flash slot timebase
    logic slot_tick;
    assign slot_tick = (slot_cnt_ff == SLOT_CYCLES - 1);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slot_cnt_ff <= 32'h0000_0000;
            slot_ff <= 3'h0;
        end else if (slot_tick) begin
            slot_cnt_ff <= 32'h0000_0000;
            slot_ff <= slot_ff + 3'h1;
        end else begin
            slot_cnt_ff <= slot_cnt_ff + 32'h0000_0001;
        end
    end
    logic flash;
    logic single_flash;
    logic double_flash;
    assign flash = ~slot_ff[1];
    assign single_flash = (slot_ff[2:1] == 2'h0);
    assign double_flash = (slot_ff == 3'h0) | (slot_ff == 3'h2);

    // Reset switch press qualification
    logic valid_reset;
    assign valid_reset = switch_prev_ff & ~switch_closed
                         & (hold_cnt_ff >= RESET_MIN_CYCLES)
                         & (hold_cnt_ff <= RESET_MAX_CYCLES);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            switch_prev_ff <= 1'b0;
            hold_cnt_ff <= 32'h0000_0000;
        end else begin
            switch_prev_ff <= switch_closed;
            if (!switch_closed) begin
                hold_cnt_ff <= 32'h0000_0000;
            end else if (hold_cnt_ff != 32'hFFFF_FFFF) begin
                hold_cnt_ff <= hold_cnt_ff + 32'h0000_0001;
            end
        end
    end

    // Power-up sequence and lockout
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= ST_LAMP;
            phase_timer_ff <= 5'h00;
        end else begin
            if (slot_tick) begin
                phase_timer_ff <= phase_timer_ff + 5'h01;
            end
            case (state_ff)
                ST_LAMP: begin
                    if (slot_tick && phase_timer_ff == 5'(LAMP_SLOTS - 1)) begin
                        state_ff <= ST_SCAN;
                        phase_timer_ff <= 5'h00;
                    end
                end
                ST_SCAN: begin
                    if (slot_tick && phase_timer_ff == 5'(SCAN_SLOTS - 1)) begin
                        state_ff <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (lockout_fault) begin
                        state_ff <= ST_LOCKOUT;
                    end
                end
                ST_LOCKOUT: begin
                    if (valid_reset && !lockout_fault) begin
                        state_ff <= ST_RUN;
                    end
                end
                default: begin
                    state_ff <= ST_LOCKOUT;
                end
            endcase
        end
    end

    // Latch bookkeeping; a trip sets it, a valid reset on clear beams releases it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            latched_ff <= 1'b1;
        end else if (!run_ok) begin
            latched_ff <= 1'b1;
        end else if (valid_reset) begin
            latched_ff <= 1'b0;
        end
    end

    logic nxt_out;
    assign nxt_out = ctrl_ff.latch_mode ? (run_ok & ~latched_ff)
                                        : run_ok;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            outputs_ff <= 2'h0;
        end else begin
            outputs_ff <= {nxt_out, nxt_out};
        end
    end

    // Indicator and display selection
    rx_lamps_t nxt_rx;
    tx_lamps_t nxt_tx;
    logic [NUM_ZONES-1:0] nxt_zg;
    logic [NUM_ZONES-1:0] nxt_zr;
    logic [NUM_ZONES-1:0] zone_blocked;
    display_t nxt_disp;
    always_comb begin
        for (int z = 0; z < NUM_ZONES; z++) begin
            zone_blocked[z] = |beams[z*BPZ +: BPZ];
        end
    end
    always_comb begin
        nxt_rx = '{red: 1'b1, green: 1'b0, amber: 1'b1};
        nxt_tx = '{red: 1'b0, green: 1'b1};
        nxt_zg = ~zone_blocked;
        nxt_zr = zone_blocked;
        nxt_disp = '{kind: DISP_COUNT, value: blocked_count};
        case (state_ff)
            ST_LAMP: begin
                nxt_rx = '{red: flash, green: flash, amber: flash};
                nxt_tx = '{red: flash, green: flash};
                nxt_zg = {NUM_ZONES{flash}};
                nxt_zr = {NUM_ZONES{flash}};
                nxt_disp = '{kind: DISP_LAMP, value: 8'hFF};
            end
            ST_SCAN: begin
                nxt_rx.amber = 1'b0;
                nxt_zg = '0;
                nxt_zr = '0;
                nxt_disp = '{kind: DISP_SCAN, value: {4'h0, ctrl_ff.scan_code}};
            end
            ST_LOCKOUT: begin
                nxt_rx = '{red: single_flash, green: 1'b0, amber: 1'b0};
                nxt_tx = '{red: single_flash, green: 1'b0};
                nxt_zg = '0;
                nxt_zr = '0;
                nxt_disp = '{kind: DISP_BLANK, value: 8'h00};
            end
            ST_RUN: begin
                if (test_open) begin
                    nxt_tx.green = flash;
                    nxt_zr = '1;
                    nxt_zg = '0;
                    if (NUM_BEAMS == 10) begin
                        nxt_zr[0] = 1'b0;
                        nxt_zg[0] = 1'b1;
                    end
                    nxt_disp.value = 8'(NUM_BEAMS - 1);
                end else if (beams[0]) begin
                    nxt_zg = '0;
                    nxt_zr = '0;
                    nxt_zr[0] = 1'b1;
                    nxt_disp = '{kind: DISP_CH1, value: CHANNEL_ONE_MISALIGNED_CODE};
                end else if (clear_ok && ctrl_ff.latch_mode && latched_ff) begin
                    nxt_rx.amber = double_flash;
                    nxt_zg = '1;
                    nxt_zr = '0;
                end else if (clear_ok) begin
                    nxt_rx.red = 1'b0;
                    nxt_rx.green = ctrl_ff.reduced_resolution_switch ? flash : 1'b1;
                end
            end
            default: begin
                nxt_rx = '{red: 1'b1, green: 1'b0, amber: 1'b0};
            end
        endcase
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_lamps_ff <= '0;
            tx_lamps_ff <= '0;
            zone_green_ff <= '0;
            zone_red_ff <= '0;
            display_ff <= '{kind: DISP_BLANK, value: 8'h00};
        end else begin
            rx_lamps_ff <= nxt_rx;
            tx_lamps_ff <= nxt_tx;
            zone_green_ff <= nxt_zg;
            zone_red_ff <= nxt_zr;
            display_ff <= nxt_disp;
        end
    end

    // APB register file
    logic wr_access;
    logic rd_setup;
    logic mapped;
    logic [EV_NUM-1:0] events;
    assign wr_access = psel & penable & pwrite;
    assign rd_setup = psel & ~penable;
    assign mapped = (paddr == OFS_CTRL) | (paddr == OFS_STATE) | (paddr == OFS_BEAMS)
                    | (paddr == OFS_IRQ_STATUS) | (paddr == OFS_IRQ_MASK);
    assign events[EV_TRIP] = outputs_ff[0] & ~nxt_out;
    assign events[EV_LOCKOUT] = (state_ff == ST_RUN) & lockout_fault;
    assign events[EV_RESET] = valid_reset;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= '{latch_mode: CTRL_LATCH_RST, reduced_resolution_switch: CTRL_RR_RST,
                         external_device_monitor: EDM_TWO_CHANNEL,
                         scan_code: SCAN_CODE_RST};
            ev_mask_ff <= '0;
        end else if (wr_access && paddr == OFS_CTRL) begin
            ctrl_ff <= pwdata[CTRL_SCAN_LSB+3:0];
        end else if (wr_access && paddr == OFS_IRQ_MASK) begin
            ev_mask_ff <= pwdata[EV_NUM-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ev_status_ff <= '0;
        end else if (wr_access && paddr == OFS_IRQ_STATUS) begin
            ev_status_ff <= (ev_status_ff & ~pwdata[EV_NUM-1:0]) | events;
        end else begin
            ev_status_ff <= ev_status_ff | events;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
        end else if (rd_setup) begin
            pslverr_ff <= ~mapped;
            case (paddr)
                OFS_CTRL: prdata_ff <= {24'h00_0000, ctrl_ff};
                OFS_STATE: prdata_ff <= {16'h0000, blocked_count, 1'b0, latched_ff,
                                         test_open, switch_closed, 2'(state_ff), outputs_ff};
                OFS_BEAMS: prdata_ff <= 32'(beams);
                OFS_IRQ_STATUS: prdata_ff <= {29'h0000_0000, ev_status_ff};
                OFS_IRQ_MASK: prdata_ff <= {29'h0000_0000, ev_mask_ff};
                default: prdata_ff <= 32'h0000_0000;
            endcase
        end
    end

    assign prdata = prdata_ff;
    assign pready = psel & penable;
    assign pslverr = psel & penable & pslverr_ff;
    assign irq = |(ev_status_ff & ev_mask_ff);
    assign safety_output_pair = outputs_ff;
    assign rx_lamps = rx_lamps_ff;
    assign tx_lamps = tx_lamps_ff;
    assign zone_green = zone_green_ff;
    assign zone_red = zone_red_ff;
    assign display = display_ff;

    // Checks
    lockout_dark_a: assert property (@(posedge pclk) disable iff (!presetn)
        state_ff == ST_LOCKOUT |=> zone_green == '0 && zone_red == '0
            && !rx_lamps.amber && safety_output_pair == 2'h0 && rx_lamps.red == $past(single_flash))
        else $error("lockout lamps wrong");
    emitter_test_a: assert property (@(posedge pclk) disable iff (!presetn)
        state_ff == ST_RUN && test_open |=> tx_lamps.green == $past(flash))
        else $error("emitter test flash wrong");
    latch_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
        run_ok && !beams[0] && ctrl_ff.latch_mode && latched_ff
        |=> rx_lamps.red && zone_green == '1 && rx_lamps.amber == $past(double_flash))
        else $error("latch waiting lamps wrong");
    latch_outputs_a: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_ff.latch_mode && latched_ff |=> safety_output_pair == 2'h0)
        else $error("latched outputs on");
    run_green_a: assert property (@(posedge pclk) disable iff (!presetn)
        run_ok && !beams[0] && !(ctrl_ff.latch_mode && latched_ff)
        |=> !rx_lamps.red && rx_lamps.amber
            && rx_lamps.green == ($past(ctrl_ff.reduced_resolution_switch) ? $past(flash) : 1'b1))
        else $error("clear lamps wrong");
    blocked_count_a: assert property (@(posedge pclk) disable iff (!presetn)
        state_ff == ST_RUN && !test_open && !beams[0] && !clear_ok
        |=> rx_lamps.red && rx_lamps.amber && display.value == $past(blocked_count)
            && zone_red == $past(zone_blocked))
        else $error("blocked display wrong");
    sync_beam_a: assert property (@(posedge pclk) disable iff (!presetn)
        state_ff == ST_RUN && !test_open && beams[0]
        |=> zone_red[0] && zone_red[NUM_ZONES-1:1] == '0 && zone_green == '0
            && display.kind == DISP_CH1 && safety_output_pair == 2'h0)
        else $error("sync beam lamps wrong");
    test_count_a: assert property (@(posedge pclk) disable iff (!presetn)
        state_ff == ST_RUN && test_open
        |=> display.value == 8'(NUM_BEAMS - 1) && zone_red[NUM_ZONES-1:1] == '1
            && safety_output_pair == 2'h0)
        else $error("test open display wrong");
    lamp_order_a: assert property (@(posedge pclk) disable iff (!presetn)
        state_ff == ST_SCAN |-> $past(state_ff) inside {ST_LAMP, ST_SCAN})
        else $error("scan shown without lamp test");
    reduced_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
        run_ok && permitted && !ctrl_ff.latch_mode |=> safety_output_pair == 2'h3)
        else $error("reduced resolution tripped");
    trip_auto_a: assert property (@(posedge pclk) disable iff (!presetn)
        !ctrl_ff.latch_mode |=> safety_output_pair == {2{$past(run_ok)}})
        else $error("trip mode outputs wrong");

endmodule : curtain_receiver
`default_nettype wire

// File: verilog/curtain_pkg.sv
// Shared constants, register map and carrier types of the light curtain receiver.
// Assumes a single 100 MHz clock domain and a 32-bit APB register bus.
package curtain_pkg;

    // Clock and timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int FLASH_SLOT_MS = 125;
    localparam int FLASH_SLOT_CYC = FLASH_SLOT_MS * 1000000 / CLK_PERIOD_NS;
    localparam int RESET_MIN_MS = 250;
    localparam int RESET_MIN_CYC = (RESET_MIN_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESET_MAX_MS = 2000;
    localparam int RESET_MAX_CYC = RESET_MAX_MS * 1000000 / CLK_PERIOD_NS;
    localparam int LAMP_SLOTS = 16;
    localparam int SCAN_SLOTS = 8;

    // Register byte offsets
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_STATE = 12'h004;
    localparam logic [11:0] OFS_BEAMS = 12'h008;
    localparam logic [11:0] OFS_IRQ_STATUS = 12'h00C;
    localparam logic [11:0] OFS_IRQ_MASK = 12'h010;

    // Control field positions
    localparam int CTRL_LATCH_BIT = 0;
    localparam int CTRL_RR_BIT = 1;
    localparam int CTRL_EDM_LSB = 2;
    localparam int CTRL_SCAN_LSB = 4;

    // Control reset values: trip output, two-channel monitor, reduced resolution off, scan 1
    localparam logic CTRL_LATCH_RST = 1'b0;
    localparam logic CTRL_RR_RST = 1'b0;
    localparam logic [1:0] EDM_TWO_CHANNEL = 2'h2;
    localparam logic [3:0] SCAN_CODE_RST = 4'h1;

    // Interrupt event bits
    localparam int EV_TRIP = 0;
    localparam int EV_LOCKOUT = 1;
    localparam int EV_RESET = 2;
    localparam int EV_NUM = 3;

    // Value shown by the display for the channel-one misaligned code
    localparam logic [7:0] CHANNEL_ONE_MISALIGNED_CODE = 8'hC1;

    typedef enum logic [2:0] {
        DISP_BLANK,
        DISP_LAMP,
        DISP_SCAN,
        DISP_COUNT,
        DISP_CH1
    } disp_kind_t;

    typedef struct packed {
        disp_kind_t kind;
        logic [7:0] value;
    } display_t;

    typedef struct packed {
        logic red;
        logic green;
        logic amber;
    } rx_lamps_t;

    typedef struct packed {
        logic red;
        logic green;
    } tx_lamps_t;

    // Packed from the top down so fields land on the positions above
    typedef struct packed {
        logic [3:0] scan_code;
        logic [1:0] external_device_monitor;
        logic reduced_resolution_switch;
        logic latch_mode;
    } ctrl_t;

endpackage : curtain_pkg

// File: verilog/pin_sync3.sv
// Three-stage input synchroniser with agreement filter.
// Assumes inputs are asynchronous pins; output changes once stages two and three agree.
`timescale 1ns/1ns
`default_nettype none
module pin_sync3 #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Pin side
    input wire logic [WIDTH-1:0] pin_in,
    // Synchronised side
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1_ff;
    logic [WIDTH-1:0] stage2_ff;
    logic [WIDTH-1:0] stage3_ff;
    logic [WIDTH-1:0] out_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage1_ff <= INIT;
            stage2_ff <= INIT;
            stage3_ff <= INIT;
        end else begin
            stage1_ff <= pin_in;
            stage2_ff <= stage1_ff;
            stage3_ff <= stage2_ff;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_ff <= INIT;
        end else begin
            for (int i = 0; i < WIDTH; i++) begin
                if (stage2_ff[i] == stage3_ff[i]) begin
                    out_ff[i] <= stage3_ff[i];
                end
            end
        end
    end

    assign sync_out = out_ff;

endmodule : pin_sync3
`default_nettype wire

// File: verif/curtain_far_side.sv
// Far-side model: emitter beams, emitter test input and operator reset switch.
// Assumes bench commands change just after a rising pclk edge.
`timescale 1ns/1ns
`default_nettype none
module curtain_far_side #(
    parameter int NUM_BEAMS = 16
) (
    // Clock
    input wire logic pclk,
    // Bench commands
    input wire logic [NUM_BEAMS-1:0] beams_cmd,
    input wire logic test_cmd,
    // Receiver pins
    output logic [NUM_BEAMS-1:0] beam_blocked = '0,
    output logic test_input_open = 1'b0,
    output logic reset_switch_closed = 1'b0
);

    // Optical path and test wire follow commands one cycle later
    always @(posedge pclk) begin
        beam_blocked <= beams_cmd;
        test_input_open <= test_cmd;
    end

    // Normally open switch closed for a bounded hold, then reopened
    task press(input int hold);
        reset_switch_closed <= 1'b1;
        repeat (hold) @(posedge pclk);
        reset_switch_closed <= 1'b0;
    endtask : press
endmodule : curtain_far_side
`default_nettype wire

// File: verif/curtain_receiver_tb.sv
// Self-checking bench for the curtain receiver: APB, beams, reset switch, lamps.
// Assumes shortened slot and reset-hold parameters on the receiver.
`timescale 1ns/1ns
`default_nettype none
module curtain_receiver_tb;
    import curtain_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, lockout_fault = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd_data;
    logic pready, pslverr, irq, rd_err, test_cmd = 0;
    logic [15:0] beams_cmd = '0, beam_blocked;
    logic test_input_open, reset_switch_closed;
    logic [1:0] safety_output_pair;
    logic [7:0] zone_green, zone_red;
    rx_lamps_t rx_lamps;
    tx_lamps_t tx_lamps;
    display_t display;
    logic [35:0] note_q[$];
    int fail_count = 0, compares = 0, seed = 31, idx;

    initial forever #5 pclk = ~pclk;

    curtain_far_side i_curtain_far_side (.pclk(pclk), .beams_cmd(beams_cmd),
        .test_cmd(test_cmd), .beam_blocked(beam_blocked),
        .test_input_open(test_input_open), .reset_switch_closed(reset_switch_closed));

    curtain_receiver #(.SLOT_CYCLES(4), .RESET_MIN_CYCLES(20), .RESET_MAX_CYCLES(100))
    i_curtain_receiver (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .beam_blocked(beam_blocked), .test_input_open(test_input_open),
        .reset_switch_closed(reset_switch_closed), .lockout_fault(lockout_fault),
        .safety_output_pair(safety_output_pair), .irq(irq), .rx_lamps(rx_lamps),
        .tx_lamps(tx_lamps), .zone_green(zone_green), .zone_red(zone_red), .display(display));

    function automatic logic [31:0] observe(input logic [3:0] id);
        case (id)
            4'h0: return rd_data;
            4'h1: return {30'h0, safety_output_pair};
            4'h2: return {24'h0, zone_red};
            4'h3: return {24'h0, zone_green};
            4'h4: return {21'h0, display};
            4'h5: return {31'h0, irq};
            4'h6: return {29'h0, rx_lamps};
            4'h7: return {31'h0, rd_err};
            4'h8: return {29'h0, display.kind};
            4'h9: return {31'h0, rx_lamps.amber};
            default: return {30'h0, tx_lamps};
        endcase
    endfunction : observe

    task check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task complete_run;
        $display("Compares %0d, mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : complete_run

    task note_exp(input logic [3:0] id, input logic [31:0] v);
        note_q.push_back({id, v});
        @(posedge pclk);
    endtask : note_exp

    // One APB transfer, entered right after a rising edge
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd_data = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    // All queued notes compared, oldest first, on the falling edge once outputs have settled
    always @(negedge pclk) begin
        while (note_q.size() > 0) begin
            check(observe(note_q[0][35:32]), note_q[0][31:0]);
            void'(note_q.pop_front());
        end
    end

    initial begin
        repeat (3000) @(posedge pclk);
        fail_count++;
        complete_run();
    end

    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, OFS_CTRL, 32'h0);
        note_exp(4'h0, 32'h18);
        apb(1'b0, 12'hFFC, 32'h0);
        note_exp(4'h7, 32'h1);
        note_exp(4'h8, DISP_LAMP);
        repeat (70) @(posedge pclk);
        note_exp(4'h4, {21'h0, DISP_SCAN, 8'h01});
        repeat (40) @(posedge pclk);
        note_exp(4'h1, 32'h3);
        note_exp(4'h3, 32'hFF);
        note_exp(4'h6, 32'h3);
        note_exp(4'hA, 32'h1);
        apb(1'b1, OFS_IRQ_MASK, 32'h1);
        repeat (3) begin
            idx = 1 + int'($unsigned($random(seed)) % 15);
            beams_cmd <= 16'h1 << idx;
            repeat (8) @(posedge pclk);
            note_exp(4'h1, 32'h0);
            note_exp(4'h2, 32'h1 << (idx / 2));
            note_exp(4'h4, {21'h0, DISP_COUNT, 8'h01});
            note_exp(4'h6, 32'h5);
            note_exp(4'h5, 32'h1);
            beams_cmd <= 16'h0;
            repeat (8) @(posedge pclk);
            note_exp(4'h1, 32'h3);
            apb(1'b1, OFS_IRQ_STATUS, 32'h1);
            note_exp(4'h5, 32'h0);
        end
        apb(1'b1, OFS_IRQ_MASK, 32'h0);
        beams_cmd <= 16'h0100;
        repeat (8) @(posedge pclk);
        note_exp(4'h5, 32'h0);
        apb(1'b0, OFS_IRQ_STATUS, 32'h0);
        note_exp(4'h0, 32'h1);
        apb(1'b1, OFS_IRQ_STATUS, 32'h1);
        apb(1'b1, OFS_CTRL, 32'h2A);
        beams_cmd <= 16'h0030;
        repeat (8) @(posedge pclk);
        note_exp(4'h1, 32'h3);
        beams_cmd <= 16'h0070;
        repeat (8) @(posedge pclk);
        note_exp(4'h1, 32'h0);
        beams_cmd <= 16'h0001;
        repeat (8) @(posedge pclk);
        note_exp(4'h2, 32'h1);
        note_exp(4'h3, 32'h0);
        note_exp(4'h4, {21'h0, DISP_CH1, CHANNEL_ONE_MISALIGNED_CODE});
        beams_cmd <= 16'h0;
        test_cmd <= 1'b1;
        repeat (8) @(posedge pclk);
        note_exp(4'h4, {21'h0, DISP_COUNT, 8'h0F});
        note_exp(4'h2, 32'hFF);
        apb(1'b1, OFS_CTRL, 32'h29);
        test_cmd <= 1'b0;
        repeat (8) @(posedge pclk);
        note_exp(4'h1, 32'h0);
        note_exp(4'h3, 32'hFF);
        i_curtain_far_side.press(40);
        repeat (12) @(posedge pclk);
        note_exp(4'h1, 32'h3);
        lockout_fault <= 1'b1;
        repeat (8) @(posedge pclk);
        note_exp(4'h3, 32'h0);
        note_exp(4'h2, 32'h0);
        note_exp(4'h9, 32'h0);
        note_exp(4'h1, 32'h0);
        apb(1'b0, OFS_IRQ_STATUS, 32'h0);
        note_exp(4'h0, 32'h7);
        complete_run();
    end
endmodule : curtain_receiver_tb
`default_nettype wire
